// ===== microstep_sequencer.sv
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module microstep_sequencer
  import microstep_pkg::*;
#(
  parameter int REST_TICK_COUNT = REST_TICKS,
  parameter int TICK_COUNT      = TICK_CYCLES,
  parameter int OFF_TICK_COUNT  = OFF_TICKS
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        STEP_IN,
  input  wire logic        DIR_IN,
  input  wire logic        DISABLE_IN,
  input  wire logic [2:0]  REMOTE_RES_SELECT,
  input  wire logic        RES_SELECT_BIT0,
  input  wire logic        RES_SELECT_BIT1,
  input  wire logic        RES_SELECT_BIT2,
  input  wire logic        STEP_EDGE_SELECT,
  input  wire logic        DIR_POLARITY_SELECT,
  input  wire logic        REST_RIPPLE_REDUCE_EN,
  input  wire logic        TRIP_A,
  input  wire logic        TRIP_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output phase_ref_type    PHASE_REF_A,
  output phase_ref_type    PHASE_REF_B,
  output bridge_ctl_type   BRIDGE_A,
  output bridge_ctl_type   BRIDGE_B
);
  localparam int         SYNC_W    = 14;
  localparam logic [7:0] TICK_LAST = 8'(TICK_COUNT - 1);
  localparam logic [15:0] REST_LIM = 16'(REST_TICK_COUNT);

  // asynchronous pins, two flops each
  logic [SYNC_W-1:0] pins_s;

  in_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk      (CLOCK),
    .rstn     (RSTN),
    .async_in ({STEP_IN,
                DIR_IN,
                DISABLE_IN,
                REMOTE_RES_SELECT,
                RES_SELECT_BIT2,
                RES_SELECT_BIT1,
                RES_SELECT_BIT0,
                STEP_EDGE_SELECT,
                DIR_POLARITY_SELECT,
                REST_RIPPLE_REDUCE_EN,
                TRIP_A,
                TRIP_B}),
    .sync_out (pins_s)
  );

  wire       step_s    = pins_s[13];
  wire       dir_s     = pins_s[12];
  wire       dis_s     = pins_s[11];
  wire [2:0] remote_s  = pins_s[10:8];
  wire [2:0] local_s   = pins_s[7:5];
  wire       edge_sel  = pins_s[4];
  wire       pol_sel   = pins_s[3];
  wire       rest_en_s = pins_s[2];
  wire       trip_a_s  = pins_s[1];
  wire       trip_b_s  = pins_s[0];

  // sequencing state
  logic        step_d_r;
  logic [2:0]  sel_r;
  logic [2:0]  sel_nxt;
  logic [1:0]  quad_r;
  logic [1:0]  quad_nxt;
  logic [6:0]  frac_r;
  logic [6:0]  frac_nxt;
  logic [31:0] pos_r;
  logic [31:0] pos_nxt;
  logic [7:0]  tick_cnt_r;
  logic        us_tick_r;
  logic [15:0] rest_cnt_r;
  logic [15:0] rest_cnt_nxt;
  logic [5:0]  fast_ticks_r;
  phase_ref_type ref_a_nxt;
  phase_ref_type ref_b_nxt;

  // local switch off reads zero, so remote inputs take over
  wire [2:0] sel_in_w   = local_s | remote_s;
  wire [6:0] rate_w     = rate_of(sel_r);
  wire [6:0] frac_last  = rate_w - 7'h01;
  wire       full_step  = (sel_r == SEL_FULL_STEP);
  wire       at_zero    = (quad_r == 2'h0) && (frac_r == 7'h00);
  wire       rise_w     = step_s && !step_d_r;
  wire       fall_w     = !step_s && step_d_r;
  wire       active_w   = edge_sel ? rise_w : fall_w;
  wire       step_go    = active_w && !dis_s;
  wire       ccw_w      = !(dir_s ^ pol_sel);
  wire [8:0] idx_w      = 9'(quad_r) * 9'(rate_w) + 9'(frac_r);
  wire [8:0] idx_last   = 9'({rate_w, 2'b00}) - 9'h001;
  wire       at_rest    = (rest_cnt_r == REST_LIM);
  wire       reduce_w   = at_rest && rest_en_s;

  // position within the quarter, in 1/128 turn
  wire [11:0] scaled_w  = {frac_r, 5'h00};
  wire [11:0] fine_w    = scaled_w / {5'h00, rate_w};
  wire [6:0]  angle_a   = 7'({quad_r, 5'h00} + OFFSET_45 + {2'b00, fine_w[4:0]});
  wire [6:0]  angle_b   = angle_a + QUARTER_TURN;
  wire phase_ref_type sine_a = sine_of(angle_a);
  wire phase_ref_type sine_b = sine_of(angle_b);

  // apply new selection only at counter zero
  assign sel_nxt = at_zero ? sel_in_w : sel_r;

  always_comb begin
    quad_nxt = quad_r;
    frac_nxt = frac_r;
    if (step_go) begin
      if (ccw_w) begin
        if (frac_r >= frac_last) begin
          frac_nxt = 7'h00;
          quad_nxt = quad_r + 2'h1;
        end else begin
          frac_nxt = frac_r + 7'h01;
        end
      end else begin
        if (frac_r == 7'h00) begin
          frac_nxt = frac_last;
          quad_nxt = quad_r - 2'h1;
        end else begin
          frac_nxt = frac_r - 7'h01;
        end
      end
    end
  end

  assign pos_nxt = !step_go ? pos_r : (ccw_w ? pos_r + 32'h1 : pos_r - 32'h1);

  always_comb begin
    ref_a_nxt = sine_a;
    ref_b_nxt = sine_b;
    if (full_step) begin
      ref_a_nxt.mag = MAG_FULL;
      ref_b_nxt.mag = MAG_FULL;
    end
  end

  assign rest_cnt_nxt = step_go ? 16'h0000 :
                        (us_tick_r && !at_rest) ? rest_cnt_r + 16'h0001 : rest_cnt_r;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      step_d_r <= 1'b0;
      sel_r    <= 3'h0;
      quad_r   <= 2'h0;
      frac_r   <= 7'h00;
      pos_r    <= 32'h0;
    end else begin
      step_d_r <= step_s;
      sel_r    <= sel_nxt;
      quad_r   <= quad_nxt;
      frac_r   <= frac_nxt;
      pos_r    <= pos_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      tick_cnt_r <= 8'h00;
      us_tick_r  <= 1'b0;
      rest_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 8'h00 : tick_cnt_r + 8'h01;
      us_tick_r  <= (tick_cnt_r == TICK_LAST);
      rest_cnt_r <= rest_cnt_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PHASE_REF_A <= '0;
      PHASE_REF_B <= '0;
    end else begin
      PHASE_REF_A <= ref_a_nxt;
      PHASE_REF_B <= ref_b_nxt;
    end
  end

  // current regulation, one chopper per phase
  chopper_phase #(
    .OFF_TICK_COUNT (OFF_TICK_COUNT)
  ) u_chop_a (
    .clk        (CLOCK),
    .rstn       (RSTN),
    .us_tick    (us_tick_r),
    .trip       (trip_a_s),
    .disable_in (dis_s),
    .reduce     (reduce_w),
    .mag_zero   (PHASE_REF_A.mag == 7'h00),
    .fast_ticks (fast_ticks_r),
    .bridge     (BRIDGE_A)
  );

  chopper_phase #(
    .OFF_TICK_COUNT (OFF_TICK_COUNT)
  ) u_chop_b (
    .clk        (CLOCK),
    .rstn       (RSTN),
    .us_tick    (us_tick_r),
    .trip       (trip_b_s),
    .disable_in (dis_s),
    .reduce     (reduce_w),
    .mag_zero   (PHASE_REF_B.mag == 7'h00),
    .fast_ticks (fast_ticks_r),
    .bridge     (BRIDGE_B)
  );

  // register bus slave, zero wait states
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;

  wire        ap_take   = HSEL && HTRANS[1] && HREADY;
  wire        ap_read   = ap_take && !HWRITE;
  wire        ctrl_wr   = wr_pend_r && (wr_addr_r == CTRL_OFFSET);
  wire [5:0]  fast_w    = ctrl_wr ? HWDATA[FAST_LSB +: 6] : fast_ticks_r;
  wire [31:0] ctrl_rd   = {26'h0, fast_w};
  wire [31:0] status_rd = {13'h0,
                           ccw_w,
                           dis_s,
                           at_rest,
                           full_step,
                           sel_r,
                           3'h0,
                           idx_w};
  wire [31:0] rd_mux    = (HADDR[7:0] == CTRL_OFFSET)   ? ctrl_rd   :
                          (HADDR[7:0] == STATUS_OFFSET) ? status_rd :
                          (HADDR[7:0] == POS_OFFSET)    ? pos_r     : 32'h0;
  wire        addr_hi0  = (HADDR[31:8] == 24'h0);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r    <= 1'b0;
      wr_addr_r    <= 8'h00;
      fast_ticks_r <= FAST_RESET;
      HRDATA       <= 32'h0;
      HREADYOUT    <= 1'b1;
      HRESP        <= 1'b0;
    end else begin
      wr_pend_r    <= ap_take && HWRITE && addr_hi0;
      wr_addr_r    <= HADDR[7:0];
      fast_ticks_r <= fast_w;
      HRDATA       <= ap_read ? (addr_hi0 ? rd_mux : 32'h0) : HRDATA;
      HREADYOUT    <= 1'b1;
      HRESP        <= 1'b0;
    end
  end

  AST_RATE_45: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (sel_r == 3'h3) |-> (idx_last == 9'd179))
    else $error("select 3 does not give 45 microsteps");
  AST_RATE_127: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (sel_r == 3'h0) |-> (idx_last == 9'd507))
    else $error("select 0 does not give 127 microsteps");
  AST_FULL_STEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    full_step && $stable(sel_r) |=> PHASE_REF_A.mag == 7'h7f && PHASE_REF_B.mag == 7'h7f)
    else $error("full step without full current");
  AST_SEL_COMBINE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    at_zero && (local_s == 3'h0) |=> sel_r == $past(remote_s))
    else $error("remote select not applied");
  AST_SEL_HOLD: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !at_zero |=> $stable(sel_r))
    else $error("resolution changed away from counter zero");
  AST_WRAP_ZERO: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && ccw_w && (idx_w == idx_last) |=> idx_w == 9'h000)
    else $error("counter did not clear after four times rate steps");
  AST_ONE_STEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && ccw_w && (idx_w != idx_last) |=> idx_w == $past(idx_w) + 9'h001)
    else $error("step edge did not move one step");
  AST_BACK_STEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && !ccw_w && at_zero |=> idx_w == $past(idx_last))
    else $error("reverse step did not wrap to the last entry");
  AST_NO_STEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !step_go |=> $stable(idx_w) && $stable(pos_r))
    else $error("position moved without an active edge");
  AST_EDGE_SELECT: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !dis_s && (edge_sel ? $rose(step_s) : $fell(step_s)) |-> step_go)
    else $error("active step edge missed");
  AST_DIRECTION: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && (dir_s != pol_sel) |=> pos_r == $past(pos_r) - 32'h1)
    else $error("direction polarity wrong");
  AST_RESET_ZERO: assert property (@(posedge CLOCK)
    !RSTN |=> at_zero || RSTN)
    else $error("counter not zero after reset");
  AST_TABLE_45: assert property (@(posedge CLOCK) disable iff (!RSTN)
    at_zero && !full_step |=> PHASE_REF_A.mag == 7'h5a && PHASE_REF_B.mag == 7'h5a)
    else $error("references not at 45 degrees at counter zero");
  AST_DIS_NO_MOVE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    dis_s |=> $stable(pos_r) && $stable(idx_w))
    else $error("position moved while disabled");
  AST_DIS_IGNORED: assert property (@(posedge CLOCK) disable iff (!RSTN)
    dis_s |-> !step_go)
    else $error("step accepted while disabled");
  AST_REST_CLEAR: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go |=> !at_rest)
    else $error("rest state kept after a step");
  AST_FWD_FRAC_WRAP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && ccw_w && (frac_r >= frac_last) |=> frac_r == 7'h00)
    else $error("forward step did not wrap the fraction");
  AST_BACK_FRAC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && !ccw_w && (frac_r != 7'h00) |=> frac_r == $past(frac_r) - 7'h01)
    else $error("reverse step did not move back one entry");
  AST_POS_CCW: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && (dir_s == pol_sel) |=> pos_r == $past(pos_r) + 32'h1)
    else $error("counter-clockwise step did not advance position");
  AST_RISE_IGNORED: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !edge_sel && $rose(step_s) |-> !step_go)
    else $error("rising edge stepped with falling edge selected");
  AST_FALL_IGNORED: assert property (@(posedge CLOCK) disable iff (!RSTN)
    edge_sel && $fell(step_s) |-> !step_go)
    else $error("falling edge stepped with rising edge selected");
  AST_SEL_LOCAL: assert property (@(posedge CLOCK) disable iff (!RSTN)
    at_zero && (remote_s == 3'h0) |=> sel_r == $past(local_s))
    else $error("local select not applied");
  AST_SIGN_AT_ZERO: assert property (@(posedge CLOCK) disable iff (!RSTN)
    at_zero |=> !PHASE_REF_A.phase_polarity_bit && !PHASE_REF_B.phase_polarity_bit)
    else $error("polarity wrong at counter zero");
  AST_IDX_RANGE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    idx_w <= idx_last)
    else $error("index beyond four times rate");
  AST_FULL_FRAC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    full_step |-> frac_r == 7'h00)
    else $error("fractional position in full step");
  AST_WRAP_BACK: assert property (@(posedge CLOCK) disable iff (!RSTN)
    step_go && !ccw_w && (idx_w == 9'h001) |=> at_zero)
    else $error("reverse step did not reach counter zero");
endmodule

// ===== microstep_pkg.sv
package microstep_pkg;

  localparam int CLOCK_MHZ       = 250;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = CLOCK_MHZ * TICK_US;
  localparam int OFF_TIME_US     = 32;
  localparam int OFF_TICKS       = OFF_TIME_US / TICK_US;
  localparam int REST_TIME_US    = 10000;
  localparam int REST_TICKS      = REST_TIME_US / TICK_US;

  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] POS_OFFSET    = 8'h08;
  localparam logic [5:0] FAST_RESET    = 6'h08;
  localparam int         FAST_LSB      = 0;
  localparam int         ST_IDX_LSB    = 0;
  localparam int         ST_SEL_LSB    = 12;
  localparam int         ST_FULL_BIT   = 15;
  localparam int         ST_REST_BIT   = 16;
  localparam int         ST_DIS_BIT    = 17;
  localparam int         ST_CCW_BIT    = 18;
  localparam logic [2:0] SEL_FULL_STEP = 3'h7;
  localparam logic [6:0] MAG_FULL      = 7'h7f;
  localparam logic [6:0] OFFSET_45     = 7'h10;
  localparam logic [6:0] QUARTER_TURN  = 7'h20;

  localparam logic [6:0] SINE_QTR [0:32] = '{
    7'h00, 7'h06, 7'h0c, 7'h13, 7'h19, 7'h1f, 7'h25, 7'h2b, 7'h31, 7'h36, 7'h3c,
    7'h41, 7'h47, 7'h4c, 7'h51, 7'h55, 7'h5a, 7'h5e, 7'h62, 7'h66, 7'h6a, 7'h6d,
    7'h70, 7'h73, 7'h75, 7'h78, 7'h7a, 7'h7b, 7'h7d, 7'h7e, 7'h7e, 7'h7f, 7'h7f};

  typedef struct packed {
    logic       phase_polarity_bit;
    logic [6:0] mag;
  } phase_ref_type;

  typedef struct packed {
    logic float_en;
    logic drive;
    logic fast;
    logic slow;
  } bridge_ctl_type;

  typedef enum logic [1:0] {CH_ON, CH_FAST, CH_SLOW} chop_state_type;

  function automatic logic [6:0] rate_of(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_of = 7'h7f;
      3'h1:    rate_of = 7'h64;
      3'h2:    rate_of = 7'h5a;
      3'h3:    rate_of = 7'h2d;
      3'h4:    rate_of = 7'h19;
      3'h5:    rate_of = 7'h0a;
      3'h6:    rate_of = 7'h05;
      default: rate_of = 7'h01;
    endcase
  endfunction

  // angle in 1/128 turn; sign from the upper half
  function automatic phase_ref_type sine_of(input logic [6:0] u);
    phase_ref_type r;
    logic [5:0]    p;
    p = {1'b0, u[4:0]};
    r.phase_polarity_bit = u[6];
    r.mag = u[5] ? SINE_QTR[6'h20 - p] : SINE_QTR[p];
    return r;
  endfunction

endpackage

// ===== in_sync.sv
`timescale 1ns/100ps
module in_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ===== chopper_phase.sv
`timescale 1ns/100ps
module chopper_phase
  import microstep_pkg::*;
#(
  parameter int OFF_TICK_COUNT = OFF_TICKS
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       us_tick,
  input  wire logic       trip,
  input  wire logic       disable_in,
  input  wire logic       reduce,
  input  wire logic       mag_zero,
  input  wire logic [5:0] fast_ticks,
  output bridge_ctl_type  bridge
);
  localparam logic [5:0] OFF_LAST = 6'(OFF_TICK_COUNT - 1);

  chop_state_type state_r;
  chop_state_type state_nxt;
  logic [5:0]     off_cnt_r;
  logic [5:0]     off_cnt_nxt;
  bridge_ctl_type bridge_nxt;

  wire [5:0] fast_eff_w  = reduce ? 6'h00 : fast_ticks;
  wire       off_done_w  = us_tick && (off_cnt_r == OFF_LAST);
  wire       fast_done_w = off_cnt_r >= fast_eff_w;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CH_ON: begin
        if (trip) begin
          state_nxt = (fast_eff_w == 6'h00) ? CH_SLOW : CH_FAST;
        end
      end
      CH_FAST: begin
        if (off_done_w) begin
          state_nxt = CH_ON;
        end else if (fast_done_w) begin
          state_nxt = CH_SLOW;
        end
      end
      CH_SLOW: begin
        if (off_done_w) begin
          state_nxt = CH_ON;
        end
      end
      default: state_nxt = CH_ON;
    endcase
    if (disable_in) begin
      state_nxt = CH_ON;
    end
  end

  assign off_cnt_nxt = (state_r == CH_ON) ? 6'h00 : off_cnt_r + 6'(us_tick);

  always_comb begin
    bridge_nxt.float_en = disable_in;
    bridge_nxt.drive    = !disable_in && (state_r == CH_ON) && !mag_zero;
    bridge_nxt.fast     = !disable_in && (state_r == CH_FAST);
    bridge_nxt.slow     = !disable_in && ((state_r == CH_SLOW) || (state_r == CH_ON && mag_zero));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= CH_ON;
      off_cnt_r <= 6'h00;
      bridge    <= '{float_en: 1'b1, drive: 1'b0, fast: 1'b0, slow: 1'b0};
    end else begin
      state_r   <= state_nxt;
      off_cnt_r <= off_cnt_nxt;
      bridge    <= bridge_nxt;
    end
  end

  AST_FLOAT_WHEN_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
    disable_in |=> bridge.float_en && !bridge.drive && !bridge.fast && !bridge.slow)
    else $error("bridge not floating while disabled");
  AST_OFF_TIME_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (state_r != CH_ON) && !off_done_w && !disable_in |=> state_r != CH_ON)
    else $error("off time ended early");
  AST_OFF_TIME_END: assert property (@(posedge clk) disable iff (!rstn)
    (state_r != CH_ON) && off_done_w |=> state_r == CH_ON ##1 bridge.drive || mag_zero
      || disable_in || $past(disable_in))
    else $error("off time did not end after its count");
  AST_FAST_FIRST: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == CH_ON) && trip && !disable_in && (fast_eff_w != 6'h00)
      |=> (state_r == CH_FAST) ##1 (bridge.fast || $past(disable_in)))
    else $error("off time did not start with fast recirculation");
  AST_REST_SLOW_ONLY: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == CH_ON) && trip && !disable_in && reduce |=> state_r == CH_SLOW)
    else $error("fast recirculation used at rest with reduction on");
endmodule

// ===== step_ctrl.sv
`timescale 1ns/100ps
module step_ctrl #(
  parameter int HALF   = 8,
  parameter int SETTLE = 1300
) (
  input  wire logic  clk,
  output logic       step_pin,
  output logic [2:0] remote_sel
);
  int cnt  = 0;
  int rate = 127;

  initial begin
    step_pin   = 1'b0;
    remote_sel = 3'h0;
  end

  // one pin level change, d is the expected move
  task automatic level(input logic l, input int d);
    step_pin <= l;
    cnt = (cnt + d + 4 * rate) % (4 * rate);
  endtask

  task automatic steps(input int n, input int d);
    repeat (n) begin
      step_pin <= 1'b1;
      repeat (HALF) @(posedge clk);
      step_pin <= 1'b0;
      repeat (HALF) @(posedge clk);
      cnt = (cnt + d + 4 * rate) % (4 * rate);
    end
  endtask

  // well past the settle time after the last edge, only at a group boundary
  task automatic new_sel(input logic [2:0] s, input int r);
    repeat (SETTLE) @(posedge clk);
    if (cnt == 0) begin
      remote_sel <= s;
      rate = r;
    end
  endtask
endmodule

// ===== microstep_sequencer_tb.sv
`timescale 1ns/100ps
module microstep_sequencer_tb
  import microstep_pkg::*;
;
  logic           CLOCK, RSTN, STEP_IN, DIR_IN, DISABLE_IN, TRIP_A, TRIP_B;
  logic           RES_SELECT_BIT0, RES_SELECT_BIT1, RES_SELECT_BIT2;
  logic           STEP_EDGE_SELECT, DIR_POLARITY_SELECT, REST_RIPPLE_REDUCE_EN;
  logic           HSEL, HWRITE, HREADYOUT, HRESP;
  logic [1:0]     HTRANS;
  logic [2:0]     HSIZE, REMOTE_RES_SELECT;
  logic [31:0]    HADDR, HWDATA, HRDATA, rdata;
  phase_ref_type  PHASE_REF_A, PHASE_REF_B;
  bridge_ctl_type BRIDGE_A, BRIDGE_B;
  logic [31:0]    a_ctrl = {24'h0, CTRL_OFFSET};
  logic [31:0]    a_stat = {24'h0, STATUS_OFFSET};
  logic [31:0]    a_pos  = {24'h0, POS_OFFSET};
  int             error_cnt = 0, n_compared = 0, cyc = 0, exp_pos = 0, fc, oc;
  typedef struct {logic e, d, p; int rise, fall;} row_type;
  row_type        rows [8] = '{'{1, 1, 1, 1, 0}, '{1, 1, 0, -1, 0}, '{1, 0, 1, -1, 0},
    '{1, 0, 0, 1, 0}, '{0, 1, 1, 0, 1}, '{0, 1, 0, 0, -1}, '{0, 0, 1, 0, -1},
    '{0, 0, 0, 0, 1}};
  int             rate_tab [8] = '{127, 100, 90, 45, 25, 10, 5, 1};

  microstep_sequencer #(.REST_TICK_COUNT(20), .TICK_COUNT(4), .OFF_TICK_COUNT(32))
  microstep_sequencer_inst (.CLOCK(CLOCK), .RSTN(RSTN), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN),
    .DISABLE_IN(DISABLE_IN), .REMOTE_RES_SELECT(REMOTE_RES_SELECT),
    .RES_SELECT_BIT0(RES_SELECT_BIT0), .RES_SELECT_BIT1(RES_SELECT_BIT1),
    .RES_SELECT_BIT2(RES_SELECT_BIT2), .STEP_EDGE_SELECT(STEP_EDGE_SELECT),
    .DIR_POLARITY_SELECT(DIR_POLARITY_SELECT), .REST_RIPPLE_REDUCE_EN(REST_RIPPLE_REDUCE_EN),
    .TRIP_A(TRIP_A), .TRIP_B(TRIP_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PHASE_REF_A(PHASE_REF_A),
    .PHASE_REF_B(PHASE_REF_B), .BRIDGE_A(BRIDGE_A), .BRIDGE_B(BRIDGE_B));

  step_ctrl step_ctrl_inst (.clk(CLOCK), .step_pin(STEP_IN), .remote_sel(REMOTE_RES_SELECT));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      error_cnt++;
    end
  endtask

  // single word transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    HSIZE <= 3'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rdata = HRDATA;
    chk({31'h0, HRESP}, 32'h0, "resp");
  endtask

  // trip phase a, count off cycles and fast cycles
  task automatic chop(output int f, output int o);
    f = 0;
    o = 0;
    TRIP_A <= 1'b1;
    while (BRIDGE_A.drive === 1'b1 && o < 50) begin
      @(posedge CLOCK);
      o++;
    end
    TRIP_A <= 1'b0;
    o = 0;
    while (BRIDGE_A.drive !== 1'b1 && o < 400) begin
      @(posedge CLOCK);
      o++;
      if (BRIDGE_A.fast === 1'b1) f++;
    end
  endtask

  initial begin
    RSTN = 1'b0;
    {DIR_IN, DISABLE_IN, TRIP_A, TRIP_B, HSEL, HWRITE} = 6'h00;
    {RES_SELECT_BIT0, RES_SELECT_BIT1, RES_SELECT_BIT2} = 3'h0;
    {STEP_EDGE_SELECT, DIR_POLARITY_SELECT, REST_RIPPLE_REDUCE_EN} = 3'h6;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    wt(6);
    chk({28'h0, BRIDGE_A}, 32'h8, "float in reset");
    RSTN <= 1'b1;
    wt(10);
    chk({16'h0, PHASE_REF_A, PHASE_REF_B}, 32'h5a5a, "refs after reset");
    ahb(1'b0, a_ctrl, 32'h0);
    chk(rdata, {26'h0, FAST_RESET}, "ctrl reset");
    ahb(1'b1, a_stat, 32'hffffffff);
    ahb(1'b0, a_stat, 32'h0);
    chk({17'h0, rdata[14:0]}, 32'h0, "status reset");
    ahb(1'b0, 32'h40, 32'h0);
    chk(rdata, 32'h0, "unmapped");
    foreach (rows[i]) begin
      STEP_EDGE_SELECT <= rows[i].e;
      DIR_IN <= rows[i].d;
      DIR_POLARITY_SELECT <= rows[i].p;
      wt(10);
      step_ctrl_inst.level(1'b1, rows[i].rise);
      exp_pos += rows[i].rise;
      wt(10);
      ahb(1'b0, a_pos, 32'h0);
      chk(rdata, exp_pos, "after rise");
      step_ctrl_inst.level(1'b0, rows[i].fall);
      exp_pos += rows[i].fall;
      wt(10);
      ahb(1'b0, a_pos, 32'h0);
      chk(rdata, exp_pos, "after fall");
      ahb(1'b0, a_stat, 32'h0);
      chk({31'h0, rdata[18]}, {31'h0, rows[i].d == rows[i].p}, "ccw");
    end
    DISABLE_IN <= 1'b1;
    wt(10);
    chk({30'h0, BRIDGE_A.float_en, BRIDGE_B.float_en}, 32'h3, "float");
    step_ctrl_inst.steps(2, 0);
    wt(10);
    ahb(1'b0, a_pos, 32'h0);
    chk(rdata, exp_pos, "steps while disabled");
    ahb(1'b0, a_stat, 32'h0);
    chk({31'h0, rdata[17]}, 32'h1, "disabled flag");
    DISABLE_IN <= 1'b0;
    STEP_EDGE_SELECT <= 1'b1;
    DIR_IN <= 1'b1;
    DIR_POLARITY_SELECT <= 1'b1;
    wt(10);
    chk({31'h0, BRIDGE_A.float_en}, 32'h0, "enabled");
    for (int k = 7; k >= 0; k--) begin
      step_ctrl_inst.new_sel(3'(k), rate_tab[k]);
      wt(10);
      ahb(1'b0, a_stat, 32'h0);
      chk({28'h0, rdata[15:12]}, {28'h0, k == 7, 3'(k)}, "sel applied");
      if (k == 7) begin
        step_ctrl_inst.steps(1, 1);
        wt(10);
        chk({16'h0, PHASE_REF_A, PHASE_REF_B}, 32'h7fff, "full step");
        step_ctrl_inst.steps(3, 1);
      end else begin
        step_ctrl_inst.steps(4 * rate_tab[k], 1);
      end
      exp_pos += 4 * rate_tab[k];
      wt(10);
      ahb(1'b0, a_stat, 32'h0);
      chk({23'h0, rdata[8:0]}, 32'h0, "counter wrap");
      chk({16'h0, PHASE_REF_A, PHASE_REF_B}, k == 7 ? 32'h7f7f : 32'h5a5a, "at 45");
      ahb(1'b0, a_pos, 32'h0);
      chk(rdata, exp_pos, "position");
    end
    step_ctrl_inst.steps(1, 1);
    RES_SELECT_BIT1 <= 1'b1;
    wt(10);
    ahb(1'b0, a_stat, 32'h0);
    chk({29'h0, rdata[14:12]}, 32'h0, "sel held");
    step_ctrl_inst.steps(507, 1);
    wt(10);
    ahb(1'b0, a_stat, 32'h0);
    chk({29'h0, rdata[14:12]}, 32'h2, "sel at zero");
    RES_SELECT_BIT1 <= 1'b0;
    ahb(1'b1, a_ctrl, 32'h3);
    ahb(1'b0, a_ctrl, 32'h0);
    chk(rdata, 32'h3, "ctrl write");
    wt(10);
    chk({31'h0, BRIDGE_A.drive}, 32'h1, "drive before trip");
    chop(fc, oc);
    chk({31'h0, oc >= 122 && oc <= 130}, 32'h1, "off time");
    chk({31'h0, fc >= 8 && fc <= 13}, 32'h1, "fast part");
    REST_RIPPLE_REDUCE_EN <= 1'b1;
    wt(150);
    ahb(1'b0, a_stat, 32'h0);
    chk({31'h0, rdata[16]}, 32'h1, "at rest");
    chop(fc, oc);
    chk({31'h0, oc >= 122 && oc <= 130}, 32'h1, "rest off time");
    chk(fc, 32'h0, "no fast at rest");
    end_sim();
  end
endmodule
